// *** src/gfx_exc_pkg.sv ***
// Purpose: Constants and carriers for the graphics exception and raster unit
// Assumes: APB slave, 32-bit data, word registers at byte address 4*index
// Notes: Summary of operation follows
// Summary of operation
// - Unmasked set status flag raises interrupt
// - No new interrupt until previous acknowledged
// - Status then control read acknowledges, clears unmasked
// - Halted flag survives acknowledge, no repeat interrupt
// - Abort or halt command enters poll state
// - Illegal opcode always enters poll state
// - Six flags enter poll unless poll-masked
// - Poll entry sets exception clear bit
// - Opcode write with clear bit zero restarts
// - Restart clears flags that caused poll
// - Interrupt and poll decided independently
// - Opcode, link low, link high register layout
// - Nondrawing commands steer fetching and context
// - Drawing control sets bitmap attributes and position
// - Only color-mask-enabled bit planes change
// - Raster function applies until redefined
// - Function code is destination/source truth table
// - Block copy ignores colors, texture, pattern
package gfx_exc_pkg;
	localparam int PIX_W     = 8;
	localparam int LINK_HI_W = 6;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS  = 8'h00;
	localparam logic [7:0] IDX_BIUCTL  = 8'h01;
	localparam logic [7:0] IDX_IMASK   = 8'h02;
	localparam logic [7:0] IDX_PMASK   = 8'h03;
	localparam logic [7:0] IDX_RASTER  = 8'h04;
	localparam logic [7:0] IDX_COLORS  = 8'h05;
	localparam logic [7:0] IDX_TEXTURE = 8'h06;
	localparam logic [7:0] IDX_OPCODE  = 8'h20;
	localparam logic [7:0] IDX_LINKLO  = 8'h22;
	localparam logic [7:0] IDX_LINKHI  = 8'h24;
	// Status flag positions
	localparam int ST_HALTED  = 0;
	localparam int ST_ILLEGAL = 1;
	localparam int ST_SOFT    = 2;
	localparam int ST_PICK    = 3;
	localparam int ST_OVF_A   = 4;
	localparam int ST_OVF_B   = 5;
	localparam int ST_EXC_C   = 6;
	localparam int ST_EXC_D   = 7;
	// Opcode register fields
	localparam int OPC_LSB  = 8;
	localparam int ECLR_BIT = 0;
	// Raster register fields
	localparam int FCODE_LSB = 0;
	localparam int CMASK_LSB = 8;
	localparam int FG_LSB    = 0;
	localparam int BG_LSB    = 8;
	localparam int TRANSP_BIT = 0;
	localparam int PAT_LSB    = 16;
	// Reset values
	localparam logic [7:0]  IMASK_RST  = 8'hff;
	localparam logic [5:0]  PMASK_RST  = 6'h3f;
	localparam logic [3:0]  FCODE_RST  = 4'h5;
	localparam logic [7:0]  CMASK_RST  = 8'hff;
	localparam logic [15:0] PAT_RST    = 16'hffff;
	localparam logic [7:0]  LINK_OPC   = 8'h02;
	localparam logic [31:0] BIUCTL_VAL = 32'h0000_0000;
	typedef enum logic [1:0] {PK_DRAW = 2'h0, PK_BLIT = 2'h1, PK_CHAR = 2'h2} pix_kind_t;
	typedef struct packed {
		logic             valid;
		pix_kind_t        kind;
		logic [PIX_W-1:0] src;
		logic [PIX_W-1:0] dst;
		logic [3:0]       pat_idx;
		logic             glyph_bit;
		logic             char_opaque;
	} pix_req_t;
	typedef struct packed {
		logic             valid;
		logic             we;
		logic [PIX_W-1:0] data;
	} pix_rsp_t;
endpackage : gfx_exc_pkg

// *** src/graphics_exception_raster_op.sv ***
// Purpose: Interrupt, poll-state and raster logic of the graphics engine
// Assumes: Engine events arrive as one-cycle pulses on pclk
// Notes: APB slave with zero wait states
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module graphics_exception_raster_op
	import gfx_exc_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic [31:0]               prdata,
	input  wire logic [7:0]           event_set,
	input  wire logic                 soft_abort,
	input  wire logic                 halt_cmd,
	input  wire pix_req_t             pix_req,
	output pix_rsp_t                  pix_rsp,
	output logic                      irq,
	output logic                      halted,
	output logic                      resume_fetch,
	output logic [7:0]                resume_opcode,
	output logic [15+LINK_HI_W:0]     resume_addr
);
	typedef enum logic [1:0] {RUN = 2'b01, POLL = 2'b10} run_state_t;

	run_state_t              state_q;
	logic [7:0]              status_q;
	logic [7:0]              imask_q;
	logic [5:0]              pmask_q;
	logic [3:0]              fcode_q;
	logic [PIX_W-1:0]        cmask_q;
	logic [PIX_W-1:0]        fg_q;
	logic [PIX_W-1:0]        bg_q;
	logic                    transp_q;
	logic [15:0]             pat_q;
	logic [7:0]              opcode_q;
	logic                    eclr_q;
	logic [15:0]             link_lo_q;
	logic [LINK_HI_W-1:0]    link_hi_q;
	logic [7:0]              cause_q;
	logic                    irq_q;
	logic                    halt_irq_done_q;
	logic                    stat_read_q;
	logic [31:0]             prdata_q;
	pix_rsp_t                pix_q;

	logic                    setup;
	logic                    access;
	logic                    wr;
	logic                    rd;
	logic [7:0]              idx;
	logic                    mapped;
	logic                    ack;
	logic                    restart;
	logic [7:0]              poll_cause;
	logic                    enter_poll;
	logic [7:0]              irq_src;
	logic [7:0]              ack_clear;
	logic [7:0]              restart_clear;
	logic [31:0]             rd_mux;

	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign idx    = paddr[9:2];
	assign wr     = access && pwrite && mapped;
	assign rd     = access && !pwrite && mapped;
	assign pready = access;
	assign pslverr = access && !mapped;
	assign prdata  = prdata_q;

	always_comb
	begin
		unique case (idx)
			IDX_STATUS, IDX_BIUCTL, IDX_IMASK, IDX_PMASK, IDX_RASTER,
			IDX_COLORS, IDX_TEXTURE, IDX_OPCODE, IDX_LINKLO, IDX_LINKHI:
				mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
			default:
				mapped = 1'b0;
		endcase
	end

	// Reserved bits read as zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (idx)
			IDX_STATUS:  rd_mux[7:0] = status_q;
			IDX_BIUCTL:  rd_mux = BIUCTL_VAL;
			IDX_IMASK:   rd_mux[7:0] = imask_q;
			IDX_PMASK:   rd_mux[5:0] = pmask_q;
			IDX_RASTER:
			begin
				rd_mux[FCODE_LSB +: 4]     = fcode_q;
				rd_mux[CMASK_LSB +: PIX_W] = cmask_q;
			end
			IDX_COLORS:
			begin
				rd_mux[FG_LSB +: PIX_W] = fg_q;
				rd_mux[BG_LSB +: PIX_W] = bg_q;
			end
			IDX_TEXTURE:
			begin
				rd_mux[TRANSP_BIT]    = transp_q;
				rd_mux[PAT_LSB +: 16] = pat_q;
			end
			IDX_OPCODE:
			begin
				rd_mux[OPC_LSB +: 8] = opcode_q;
				rd_mux[ECLR_BIT]     = eclr_q;
			end
			IDX_LINKLO:  rd_mux[15:0] = link_lo_q;
			IDX_LINKHI:  rd_mux[LINK_HI_W-1:0] = link_hi_q;
			default:     rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data captured in setup so it comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (setup)
			prdata_q <= rd_mux;
	end

	// Acknowledge needs both reads, status first
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stat_read_q <= 1'b0;
		else if (rd && idx == IDX_STATUS)
			stat_read_q <= 1'b1;
		else if (rd)
			stat_read_q <= 1'b0;
	end
	assign ack = rd && idx == IDX_BIUCTL && stat_read_q;

	// Poll entry causes; illegal opcode ignores every mask
	always_comb
	begin
		poll_cause = 8'h00;
		poll_cause[ST_ILLEGAL] = status_q[ST_ILLEGAL];
		poll_cause[7:2] = status_q[7:2] & ~pmask_q;
	end
	assign enter_poll = (state_q == RUN) && (soft_abort || halt_cmd || (|poll_cause));
	assign restart = wr && idx == IDX_OPCODE && !pwdata[ECLR_BIT] && state_q == POLL;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= RUN;
		else
			unique case (state_q)
				RUN:  if (enter_poll) state_q <= POLL;
				POLL: if (restart) state_q <= RUN;
			endcase
	end
	assign halted = (state_q == POLL);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cause_q <= 8'h00;
		else if (enter_poll)
			cause_q <= poll_cause | 8'h01;
	end

	// Unmasked flags cleared on acknowledge, halted flag kept
	always_comb
	begin
		ack_clear = ack ? ~imask_q : 8'h00;
		ack_clear[ST_HALTED] = 1'b0;
		restart_clear = restart ? cause_q : 8'h00;
	end

	// Set wins over clear for every flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= 8'h00;
		else
		begin
			status_q <= (status_q & ~(ack_clear | restart_clear)) | event_set;
			if (enter_poll)
				status_q[ST_HALTED] <= 1'b1;
		end
	end

	// Halted flag may raise only one interrupt per poll entry
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			halt_irq_done_q <= 1'b0;
		else if (!status_q[ST_HALTED])
			halt_irq_done_q <= 1'b0;
		else if (ack && !imask_q[ST_HALTED])
			halt_irq_done_q <= 1'b1;
	end

	always_comb
	begin
		irq_src = status_q & ~imask_q;
		irq_src[ST_HALTED] = irq_src[ST_HALTED] && !halt_irq_done_q;
	end

	// Interrupt path has its own mask; poll entry reaches it only through the halted flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 1'b0;
		else if (ack)
			irq_q <= 1'b0;
		else if (!irq_q && (|irq_src))
			irq_q <= 1'b1;
	end
	assign irq = irq_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			eclr_q <= 1'b0;
		else if (enter_poll)
			eclr_q <= 1'b1;
		else if (wr && idx == IDX_OPCODE)
			eclr_q <= pwdata[ECLR_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			opcode_q  <= LINK_OPC;
			link_lo_q <= 16'h0000;
			link_hi_q <= '0;
		end
		else if (wr)
			unique case (idx)
				IDX_OPCODE: opcode_q <= pwdata[OPC_LSB +: 8];
				IDX_LINKLO: link_lo_q <= pwdata[15:0];
				IDX_LINKHI: link_hi_q <= pwdata[LINK_HI_W-1:0];
				default: ;
			endcase
	end

	// Fetch restarts from the written opcode and link address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resume_fetch  <= 1'b0;
			resume_opcode <= 8'h00;
			resume_addr   <= '0;
		end
		else
		begin
			resume_fetch <= restart;
			if (restart)
			begin
				resume_opcode <= pwdata[OPC_LSB +: 8];
				resume_addr   <= {link_hi_q, link_lo_q};
			end
		end
	end

	// Masks and drawing attributes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			imask_q  <= IMASK_RST;
			pmask_q  <= PMASK_RST;
			fcode_q  <= FCODE_RST;
			cmask_q  <= CMASK_RST;
			fg_q     <= '1;
			bg_q     <= '0;
			transp_q <= 1'b0;
			pat_q    <= PAT_RST;
		end
		else if (wr)
			unique case (idx)
				IDX_IMASK: imask_q <= pwdata[7:0];
				IDX_PMASK: pmask_q <= pwdata[5:0];
				IDX_RASTER:
				begin
					fcode_q <= pwdata[FCODE_LSB +: 4];
					cmask_q <= pwdata[CMASK_LSB +: PIX_W];
				end
				IDX_COLORS:
				begin
					fg_q <= pwdata[FG_LSB +: PIX_W];
					bg_q <= pwdata[BG_LSB +: PIX_W];
				end
				IDX_TEXTURE:
				begin
					transp_q <= pwdata[TRANSP_BIT];
					pat_q    <= pwdata[PAT_LSB +: 16];
				end
				default: ;
			endcase
	end

	// Raster path, one pixel per cycle, attributes assumed set beforehand
	logic [PIX_W-1:0] src_pix;
	logic [PIX_W-1:0] fn_pix;
	logic             fg_sel;
	logic             pix_we;

	always_comb
	begin
		src_pix = pix_req.src;
		fg_sel  = 1'b1;
		pix_we  = pix_req.valid;
		unique case (pix_req.kind)
			PK_DRAW:
			begin
				fg_sel  = pat_q[pix_req.pat_idx];
				src_pix = fg_sel ? fg_q : bg_q;
				pix_we  = pix_req.valid && (fg_sel || !transp_q);
			end
			PK_CHAR:
			begin
				fg_sel  = pix_req.glyph_bit;
				src_pix = fg_sel ? fg_q : bg_q;
				pix_we  = pix_req.valid && (fg_sel || pix_req.char_opaque);
			end
			default: ;
		endcase
	end

	// Code bit 3 is dest0/src0 down to bit 0 for dest1/src1
	for (genvar b = 0; b < PIX_W; b++)
	begin : g_fn
		assign fn_pix[b] = fcode_q[2'd3 - {pix_req.dst[b], src_pix[b]}];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pix_q <= '0;
		else
		begin
			pix_q.valid <= pix_req.valid;
			pix_q.we    <= pix_we;
			pix_q.data  <= (fn_pix & cmask_q) | (pix_req.dst & ~cmask_q);
		end
	end
	assign pix_rsp = pix_q;

	ack_drops_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		ack |=> !irq)
		else $error("Interrupt stayed high after acknowledge");
	irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn)
		!irq && !ack && (|irq_src) |=> irq)
		else $error("Unmasked flag did not raise interrupt");
	irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq && !ack |=> irq)
		else $error("Interrupt dropped without acknowledge");
	halt_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
		ack && status_q[ST_HALTED] && !restart |=> status_q[ST_HALTED])
		else $error("Halted flag cleared by acknowledge");
	poll_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
		!halted && (soft_abort || halt_cmd) |=> halted && status_q[ST_HALTED])
		else $error("Abort or halt did not enter poll");
	illegal_poll_a: assert property (@(posedge pclk) disable iff (!presetn)
		!halted && status_q[ST_ILLEGAL] |=> halted)
		else $error("Illegal opcode did not enter poll");
	mask_poll_a: assert property (@(posedge pclk) disable iff (!presetn)
		!halted && (|(status_q[7:2] & ~pmask_q)) |=> halted)
		else $error("Unmasked exception did not enter poll");
	eclr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(halted) |-> eclr_q)
		else $error("Exception clear bit not set on poll entry");
	restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		restart |=> !halted && resume_fetch ##1 !resume_fetch)
		else $error("Restart did not leave poll");
	cause_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		restart && event_set == 8'h00 |=> (status_q & cause_q) == 8'h00)
		else $error("Poll causes not cleared on restart");
	mask_plane_a: assert property (@(posedge pclk) disable iff (!presetn)
		pix_req.valid |=> ((pix_rsp.data ^ $past(pix_req.dst)) & ~$past(cmask_q)) == '0)
		else $error("Masked bit plane changed");
endmodule : graphics_exception_raster_op
`default_nettype wire

// *** verif/host_bus_model.sv ***
// Purpose: Host processor model issuing APB transfers to the engine
// Assumes: Master changes signals only right after a rising edge
// Notes: Released write data lines show inverted data so stale values never match
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             timed_out
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		timed_out = 1'b0;
	end
	// Bounded wait, a stuck slave must not hang the run
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		q = prdata;
		err = pslverr;
		if (pready !== 1'b1)
			timed_out = 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// *** verif/test_graphics_exception_raster_op.sv ***
// Purpose: Self-checking bench for interrupt, poll and raster logic
// Assumes: Zero wait state APB, one-cycle event pulses
// Notes: Register reads and pixel results compared with computed values
`timescale 1ns/1ps
`default_nettype none
module test_graphics_exception_raster_op
	import gfx_exc_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, timed_out, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  event_set = 8'h00;
	logic        soft_abort = 1'b0;
	logic        halt_cmd = 1'b0;
	pix_req_t    pix_req = '0;
	pix_rsp_t    pix_rsp;
	logic        irq, halted, resume_fetch;
	logic [7:0]  resume_opcode, e8;
	logic [7:0]  dv = 8'h5c;
	logic [7:0]  sv = 8'h3a;
	logic [21:0] resume_addr;
	int          errors = 0;
	int          checks = 0;
	always #2.5 pclk = ~pclk;
	host_bus_model u_host_bus_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.timed_out(timed_out));
	graphics_exception_raster_op u_graphics_exception_raster_op (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .event_set(event_set),
		.soft_abort(soft_abort), .halt_cmd(halt_cmd), .pix_req(pix_req), .pix_rsp(pix_rsp),
		.irq(irq), .halted(halted), .resume_fetch(resume_fetch), .resume_opcode(resume_opcode),
		.resume_addr(resume_addr));
	function automatic logic [11:0] ad(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction : ad
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] idx, input logic [31:0] d);
		u_host_bus_model.xfer(1'b1, ad(idx), d, rd, er);
	endtask : wr
	task rdc(input logic [7:0] idx, input logic [31:0] e);
		u_host_bus_model.xfer(1'b0, ad(idx), 32'h0000_0000, rd, er);
		chk("prdata", e, rd);
	endtask : rdc
	task pulse(input logic [7:0] ev, input logic ab, input logic hc);
		@(posedge pclk);
		event_set <= ev;
		soft_abort <= ab;
		halt_cmd <= hc;
		@(posedge pclk);
		event_set <= 8'h00;
		soft_abort <= 1'b0;
		halt_cmd <= 1'b0;
	endtask : pulse
	task edge1;
		@(posedge pclk);
		#1;
	endtask : edge1
	task pix(input pix_req_t r, input logic [9:0] e);
		@(posedge pclk);
		pix_req <= r;
		@(posedge pclk);
		pix_req.valid <= 1'b0;
		#1;
		chk("pix_rsp", {22'h0, e}, {22'h0, pix_rsp.valid, pix_rsp.we, pix_rsp.data});
	endtask : pix
	task restart;
		wr(IDX_OPCODE, 32'h0000_0200);
		#1;
		chk("halted", 0, halted);
		chk("resume_fetch", 1, resume_fetch);
		chk("resume_opcode", 32'h0000_0002, resume_opcode);
	endtask : restart
	task give_verdict;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	always @(posedge timed_out)
	begin
		errors++;
		give_verdict();
	end
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(IDX_IMASK, 32'h0000_00ff);
		rdc(IDX_PMASK, 32'h0000_003f);
		rdc(IDX_RASTER, 32'h0000_ff05);
		rdc(IDX_OPCODE, 32'h0000_0200);
		u_host_bus_model.xfer(1'b0, 12'h01c, 32'h0000_0000, rd, er);
		chk("pslverr", 1, er);
		// Soft flag unmasked for interrupt, pick flag masked
		wr(IDX_IMASK, 32'h0000_00fb);
		pulse(8'h0c, 1'b0, 1'b0);
		edge1();
		chk("irq", 1, irq);
		chk("halted", 0, halted);
		rdc(IDX_STATUS, 32'h0000_000c);
		rdc(IDX_BIUCTL, 32'h0000_0000);
		edge1();
		chk("irq", 0, irq);
		rdc(IDX_STATUS, 32'h0000_0008);
		wr(IDX_LINKLO, 32'h0000_1234);
		wr(IDX_LINKHI, 32'h0000_002a);
		pulse(8'h00, 1'b1, 1'b0);
		#1;
		chk("halted", 1, halted);
		rdc(IDX_OPCODE, 32'h0000_0201);
		rdc(IDX_STATUS, 32'h0000_0009);
		chk("irq", 0, irq);
		restart();
		chk("resume_addr", {10'h000, 22'h2a_1234}, resume_addr);
		rdc(IDX_STATUS, 32'h0000_0008);
		pulse(8'h02, 1'b0, 1'b0);
		edge1();
		chk("halted", 1, halted);
		restart();
		rdc(IDX_STATUS, 32'h0000_0008);
		// Soft flag now stops the engine yet raises no interrupt
		wr(IDX_IMASK, 32'h0000_00ff);
		wr(IDX_PMASK, 32'h0000_003e);
		pulse(8'h04, 1'b0, 1'b0);
		edge1();
		chk("halted", 1, halted);
		chk("irq", 0, irq);
		restart();
		wr(IDX_IMASK, 32'h0000_00fe);
		pulse(8'h00, 1'b0, 1'b1);
		#1;
		chk("halted", 1, halted);
		edge1();
		chk("irq", 1, irq);
		rdc(IDX_STATUS, 32'h0000_0009);
		rdc(IDX_BIUCTL, 32'h0000_0000);
		repeat (4) edge1();
		chk("irq", 0, irq);
		rdc(IDX_STATUS, 32'h0000_0009);
		restart();
		// Colors set on purpose; a blit must ignore them
		wr(IDX_COLORS, 32'h0000_33cc);
		for (int f = 0; f < 16; f++)
		begin
			wr(IDX_RASTER, {16'h0000, 8'h0f, 4'h0, 4'(f)});
			for (int i = 0; i < 8; i++)
				e8[i] = (i < 4) ? f[3 - 2 * dv[i] - sv[i]] : dv[i];
			pix({1'b1, PK_BLIT, sv, dv, 4'h0, 1'b0, 1'b0}, {2'b11, e8});
		end
		// Source function on all planes, pattern 0001, transparent
		wr(IDX_RASTER, 32'h0000_ff05);
		wr(IDX_TEXTURE, 32'h0001_0001);
		pix({1'b1, PK_DRAW, sv, dv, 4'h0, 1'b0, 1'b0}, {2'b11, 8'hcc});
		pix({1'b1, PK_DRAW, sv, dv, 4'h1, 1'b0, 1'b0}, {2'b10, 8'h33});
		pix({1'b1, PK_BLIT, sv, dv, 4'h1, 1'b0, 1'b0}, {2'b11, sv});
		pix({1'b1, PK_CHAR, sv, dv, 4'h1, 1'b0, 1'b1}, {2'b11, 8'h33});
		pix({1'b1, PK_CHAR, sv, dv, 4'h0, 1'b1, 1'b0}, {2'b11, 8'hcc});
		pix({1'b1, PK_CHAR, sv, dv, 4'h0, 1'b0, 1'b0}, {2'b10, 8'h33});
		// Reset in mid-run must drop a pending interrupt
		pulse(8'h00, 1'b0, 1'b1);
		edge1();
		chk("irq", 1, irq);
		@(posedge pclk);
		presetn <= 1'b0;
		#1;
		chk("irq", 0, irq);
		chk("halted", 0, halted);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(IDX_STATUS, 32'h0000_0000);
		rdc(IDX_IMASK, 32'h0000_00ff);
		give_verdict();
	end
endmodule : test_graphics_exception_raster_op
`default_nettype wire
